// File: logic/imdv_fifo.sv
// Purpose: Flip-flop FIFO holding acceleration samples ahead of the integrator.
// Assumes: One push and one pop per cycle at most; rst is synchronous.
// Notes: in_ready and out_valid come from registered state.
`timescale 1ns/1ns
module imdv_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Fill side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   import imdv_pkg::*;
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [PW:0] cnt;
      logic rdy;
      logic vld;
   } imdv_fifo_st_t;

   imdv_fifo_st_t s_r;
   imdv_fifo_st_t s_nxt;
   logic push;
   logic pop;

   always_comb
   begin
      s_nxt = s_r;
      push = in_valid && s_r.rdy;
      pop = out_ready && s_r.vld;
      if (push)
      begin
         s_nxt.mem[s_r.wr] = in_data;
         s_nxt.wr = (s_r.wr == PW'(DEPTH - 1)) ? '0 : s_r.wr + 1'b1;
      end
      if (pop)
      begin
         s_nxt.rd = (s_r.rd == PW'(DEPTH - 1)) ? '0 : s_r.rd + 1'b1;
      end
      s_nxt.cnt = s_r.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
      s_nxt.rdy = s_nxt.cnt != (PW + 1)'(DEPTH);
      s_nxt.vld = s_nxt.cnt != '0;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign in_ready = s_r.rdy;
   assign out_valid = s_r.vld;
   assign out_data = s_r.mem[s_r.rd];
endmodule : imdv_fifo

// File: logic/imdv_integ.sv
// Purpose: Trapezoid integration of acceleration samples over one decimation period.
// Assumes: One sample per sample tick; DEC samples make one output.
// Notes: Result is scaled by an arithmetic right shift and saturated to 32 bits.
`timescale 1ns/1ns
module imdv_integ #(
   parameter int DEC = 1,
   parameter int ACC_SHIFT = 1
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Acceleration samples.
   input wire logic smp_valid,
   input wire logic [31:0] smp_data,
   // Velocity change result.
   output logic out_valid,
   output logic [31:0] out_data
);
   import imdv_pkg::*;

   typedef struct packed {
      logic signed [47:0] acc;
      logic signed [31:0] prev;
      logic [15:0] cnt;
      logic [31:0] out;
      logic outv;
   } imdv_integ_st_t;

   imdv_integ_st_t s_r;
   imdv_integ_st_t s_nxt;
   logic signed [47:0] total;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.outv = 1'b0;
      total = s_r.acc + 48'(signed'(smp_data)) + 48'(s_r.prev);
      if (smp_valid)
      begin
         s_nxt.prev = signed'(smp_data);
         if (s_r.cnt == 16'(DEC - 1))
         begin
            s_nxt.out = imdv_sat32(64'(total >>> ACC_SHIFT));
            s_nxt.outv = 1'b1;
            s_nxt.acc = '0;
            s_nxt.cnt = '0;
         end
         else
         begin
            s_nxt.acc = total;
            s_nxt.cnt = s_r.cnt + 16'h0001;
         end
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign out_valid = s_r.outv;
   assign out_data = s_r.out;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_sat_pos_clamp: assert property (smp_valid && s_r.cnt == 16'(DEC - 1)
      && (total >>> ACC_SHIFT) > 48'sh0000_7fff_ffff |=> out_data == SAT_POS)
      else $error("positive overflow not clamped");
   a_sat_neg_clamp: assert property (smp_valid && s_r.cnt == 16'(DEC - 1)
      && (total >>> ACC_SHIFT) < -48'sh0000_8000_0000 |=> out_data == SAT_NEG)
      else $error("negative overflow not clamped");
   a_out_after_dec: assert property (smp_valid && s_r.cnt == 16'(DEC - 1) |=> out_valid)
      else $error("result missing after decimation period");
   c_sat_seen: cover property (out_valid && (out_data == SAT_POS || out_data == SAT_NEG));
endmodule : imdv_integ

// File: logic/imdv_pkg.sv
// Purpose: Shared constants for the delta velocity and gyro offset register block.
// Assumes: Byte addresses, 16-bit register words, 100 MHz core clock.
// Notes: Saturation helper is shared by the integrator and the offset adders.
package imdv_pkg;
   localparam int REG_AW = 8;
   localparam int REG_DW = 16;
   localparam int SMP_W = 32;
   localparam int AXES = 3;
   localparam int FIFO_DEPTH = 16;
   localparam logic [7:0] OFS_ZV_LO = 8'h38;
   localparam logic [7:0] OFS_ZV_HI = 8'h3a;
   localparam logic [7:0] OFS_XB_LO = 8'h40;
   localparam logic [7:0] OFS_XB_HI = 8'h42;
   localparam logic [7:0] OFS_YB_LO = 8'h44;
   localparam logic [7:0] OFS_YB_HI = 8'h46;
   localparam logic [7:0] OFS_ZB_LO = 8'h48;
   localparam logic [7:0] OFS_ZB_HI = 8'h4a;
   localparam logic [15:0] BIAS_RST = 16'h0000;
   localparam logic [15:0] RD_NONE = 16'h0000;
   localparam logic [31:0] SAT_POS = 32'h7fff_ffff;
   localparam logic [31:0] SAT_NEG = 32'h8000_0000;
   localparam int CLK_HZ = 100_000_000;
   localparam int SAMPLE_HZ = 2000;
   localparam int TICK_CYC = CLK_HZ / SAMPLE_HZ;
   localparam int DEC_DEFAULT = 1;
   localparam int ACC_SHIFT_DEFAULT = 1;

   // Clamps a wide signed value into the 32-bit two's-complement range.
   function automatic logic [31:0] imdv_sat32(input logic signed [63:0] v);
      logic [31:0] r;
      r = v[31:0];
      if (v > $signed({32'h0000_0000, SAT_POS}))
      begin
         r = SAT_POS;
      end
      else if (v < $signed({32'hffff_ffff, SAT_NEG}))
      begin
         r = SAT_NEG;
      end
      return r;
   endfunction : imdv_sat32
endpackage : imdv_pkg

// File: logic/imdv_regs.sv
// Purpose: Z delta velocity output words and gyro offset words with their datapath.
// Assumes: The register port is the serial port's word interface, byte addressed.
// Notes: Acceleration samples queue in a FIFO and drain on the 2000 Hz sample tick.
`timescale 1ns/1ns
module imdv_regs #(
   parameter int TICK_CYCLES = imdv_pkg::TICK_CYC,
   parameter int DEC = imdv_pkg::DEC_DEFAULT,
   parameter int ACC_SHIFT = imdv_pkg::ACC_SHIFT_DEFAULT,
   parameter int FIFO_DEPTH = imdv_pkg::FIFO_DEPTH
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rst,
   // Register port.
   input wire logic [imdv_pkg::REG_AW-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [imdv_pkg::REG_DW-1:0] reg_wdata,
   output logic [imdv_pkg::REG_DW-1:0] reg_rdata,
   // Z acceleration samples.
   input wire logic acc_valid,
   output logic acc_ready,
   input wire logic [imdv_pkg::SMP_W-1:0] acc_data,
   // Factory-corrected gyro rates.
   input wire logic gyro_valid,
   input wire logic [imdv_pkg::SMP_W-1:0] gyro_x_in,
   input wire logic [imdv_pkg::SMP_W-1:0] gyro_y_in,
   input wire logic [imdv_pkg::SMP_W-1:0] gyro_z_in,
   // Offset-corrected gyro rates and sample tick.
   output logic [imdv_pkg::SMP_W-1:0] gyro_x_out,
   output logic [imdv_pkg::SMP_W-1:0] gyro_y_out,
   output logic [imdv_pkg::SMP_W-1:0] gyro_z_out,
   output logic sample_tick
);
   import imdv_pkg::*;

   typedef struct packed {
      logic [5:0][15:0] bias;
      logic [AXES-1:0][31:0] gyro_lat;
      logic [AXES-1:0][31:0] gyro_out;
      logic [31:0] vel;
      logic [15:0] rdata;
      logic [31:0] tick_cnt;
      logic tick;
      logic rdy;
   } imdv_main_st_t;

   imdv_main_st_t s_r;
   imdv_main_st_t s_nxt;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [SMP_W-1:0] fifo_out_data;
   logic integ_valid;
   logic [31:0] integ_data;
   logic [AXES-1:0][SMP_W-1:0] gyro_in;
   logic [AXES-1:0][31:0] gyro_sum;
   logic [7:0] wadr;

   assign gyro_in[0] = gyro_x_in;
   assign gyro_in[1] = gyro_y_in;
   assign gyro_in[2] = gyro_z_in;
   assign wadr = {reg_addr[7:1], 1'b0};

   imdv_fifo #(
      .WIDTH(SMP_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst(rst),
      .in_valid(acc_valid),
      .in_ready(fifo_in_ready),
      .in_data(acc_data),
      .out_valid(fifo_out_valid),
      .out_ready(s_r.tick),
      .out_data(fifo_out_data)
   );

   imdv_integ #(
      .DEC(DEC),
      .ACC_SHIFT(ACC_SHIFT)
   ) u_integ (
      .core_clk(core_clk),
      .rst(rst),
      .smp_valid(s_r.tick && fifo_out_valid),
      .smp_data(fifo_out_data),
      .out_valid(integ_valid),
      .out_data(integ_data)
   );

   genvar ax;
   generate
      for (ax = 0; ax < AXES; ax++)
      begin : g_axis
         logic signed [63:0] wide;
         assign wide = 64'(signed'(s_r.gyro_lat[ax]))
            + 64'(signed'({s_r.bias[2*ax+1], s_r.bias[2*ax]}));
         assign gyro_sum[ax] = imdv_sat32(wide);
      end
   endgenerate

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.rdy = fifo_in_ready;
      s_nxt.tick = 1'b0;
      if (s_r.tick_cnt == 32'(TICK_CYCLES - 1))
      begin
         s_nxt.tick_cnt = '0;
         s_nxt.tick = 1'b1;
      end
      else
      begin
         s_nxt.tick_cnt = s_r.tick_cnt + 32'h0000_0001;
      end
      if (gyro_valid)
      begin
         s_nxt.gyro_lat = gyro_in;
      end
      if (s_r.tick)
      begin
         s_nxt.gyro_out = gyro_sum;
      end
      if (integ_valid)
      begin
         s_nxt.vel = integ_data;
      end
      if (reg_wr)
      begin
         if (wadr == OFS_XB_LO)
         begin
            s_nxt.bias[0] = reg_wdata;
         end
         else if (wadr == OFS_XB_HI)
         begin
            s_nxt.bias[1] = reg_wdata;
         end
         else if (wadr == OFS_YB_LO)
         begin
            s_nxt.bias[2] = reg_wdata;
         end
         else if (wadr == OFS_YB_HI)
         begin
            s_nxt.bias[3] = reg_wdata;
         end
         else if (wadr == OFS_ZB_LO)
         begin
            s_nxt.bias[4] = reg_wdata;
         end
         else if (wadr == OFS_ZB_HI)
         begin
            s_nxt.bias[5] = reg_wdata;
         end
      end
      if (reg_rd)
      begin
         if (wadr == OFS_ZV_LO)
         begin
            s_nxt.rdata = s_r.vel[15:0];
         end
         else if (wadr == OFS_ZV_HI)
         begin
            s_nxt.rdata = s_r.vel[31:16];
         end
         else if (wadr == OFS_XB_LO)
         begin
            s_nxt.rdata = s_r.bias[0];
         end
         else if (wadr == OFS_XB_HI)
         begin
            s_nxt.rdata = s_r.bias[1];
         end
         else if (wadr == OFS_YB_LO)
         begin
            s_nxt.rdata = s_r.bias[2];
         end
         else if (wadr == OFS_YB_HI)
         begin
            s_nxt.rdata = s_r.bias[3];
         end
         else if (wadr == OFS_ZB_LO)
         begin
            s_nxt.rdata = s_r.bias[4];
         end
         else if (wadr == OFS_ZB_HI)
         begin
            s_nxt.rdata = s_r.bias[5];
         end
         else
         begin
            s_nxt.rdata = RD_NONE;
         end
      end
   end

   // Offsets clear to zero; velocity words have no defined value but start at zero.
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign acc_ready = s_r.rdy && fifo_in_ready;
   assign gyro_x_out = s_r.gyro_out[0];
   assign gyro_y_out = s_r.gyro_out[1];
   assign gyro_z_out = s_r.gyro_out[2];
   assign sample_tick = s_r.tick;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_bias_reset_zero: assert property ($fell(rst) |-> s_r.bias == '0)
      else $error("offset words not zero after reset");
   a_xlo_write_takes: assert property (reg_wr && wadr == OFS_XB_LO
      |=> s_r.bias[0] == $past(reg_wdata))
      else $error("x offset low word write lost");
   a_xhi_write_reads: assert property (reg_wr && wadr == OFS_XB_HI ##1 !reg_wr ##1 reg_rd
      && wadr == OFS_XB_HI && !reg_wr |=> reg_rdata == $past(reg_wdata, 3))
      else $error("x offset high word readback wrong");
   a_ylo_write_takes: assert property (reg_wr && wadr == OFS_YB_LO
      |=> s_r.bias[2] == $past(reg_wdata))
      else $error("y offset low word write lost");
   a_zhi_write_takes: assert property (reg_wr && wadr == OFS_ZB_HI
      |=> s_r.bias[5] == $past(reg_wdata))
      else $error("z offset high word write lost");
   a_vel_lo_read: assert property (reg_rd && wadr == OFS_ZV_LO
      |=> reg_rdata == $past(s_r.vel[15:0]))
      else $error("velocity low word read wrong");
   a_vel_hi_read: assert property (reg_rd && wadr == OFS_ZV_HI
      |=> reg_rdata == $past(s_r.vel[31:16]))
      else $error("velocity high word read wrong");
   a_vel_read_only: assert property (reg_wr && (wadr == OFS_ZV_LO || wadr == OFS_ZV_HI)
      && !integ_valid |=> $stable(s_r.vel))
      else $error("velocity word changed by a write");
   a_tick_spacing: assert property (s_r.tick |=> !s_r.tick[*8])
      else $error("sample ticks too close");
   a_tick_period: assert property (s_r.tick_cnt <= 32'(TICK_CYCLES - 1))
      else $error("tick counter out of range");
   a_gyro_offset_sum: assert property (s_r.tick
      |=> gyro_x_out == imdv_sat32(64'(signed'($past(s_r.gyro_lat[0])))
      + 64'(signed'({$past(s_r.bias[1]), $past(s_r.bias[0])}))))
      else $error("x gyro output is not rate plus offset");
   a_vel_capture: assert property (integ_valid |=> s_r.vel == $past(integ_data))
      else $error("velocity result not stored");

   c_bias_write: cover property (reg_wr && wadr == OFS_ZB_LO);
   c_tick_drain: cover property (s_r.tick && fifo_out_valid);
   c_fifo_full: cover property (!fifo_in_ready);
   c_unmapped_read: cover property (reg_rd && wadr == 8'h50);
endmodule : imdv_regs

// File: sim/imdv_host.sv
// Purpose: Host model that reaches the register words through the serial port's word interface.
// Assumes: Requests change at the falling edge and are taken at the next rising edge.
// Notes: Released address and data lines show the inverse of their last value.
`timescale 1ns/1ns
module imdv_host (
   // Clock.
   input wire logic core_clk,
   // Register port.
   output logic [imdv_pkg::REG_AW-1:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [imdv_pkg::REG_DW-1:0] reg_wdata,
   input wire logic [imdv_pkg::REG_DW-1:0] reg_rdata
);
   import imdv_pkg::*;

   initial
   begin
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 16'h0000;
   end

   // Writes one word with a single strobe cycle.
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr

   // Reads one word; the answer is taken two cycles after the strobe is raised.
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      @(negedge core_clk);
      d = reg_rdata;
   endtask : rd
endmodule : imdv_host

// File: sim/imdv_regs_bench.sv
// Purpose: Self-checking bench for the velocity and gyro offset register block.
// Assumes: Short sample tick period of 20 cycles, decimation of one.
// Notes: Stimulus changes at the falling edge; random values use a fixed seed.
`timescale 1ns/1ns
module imdv_regs_bench;
   import imdv_pkg::*;
   localparam int TCK = 20;
   localparam logic [31:0] CORNER [6] = '{32'hffff_ffff, 32'hffff_ffff, 32'h7fff_ffff,
      32'h7fff_ffff, 32'h8000_0000, 32'h8000_0000};
   logic core_clk;
   logic rst;
   logic [7:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_wdata;
   logic [15:0] reg_rdata;
   logic acc_valid;
   logic acc_ready;
   logic [31:0] acc_data;
   logic gyro_valid;
   logic [31:0] gin [3];
   logic [31:0] gout [3];
   logic sample_tick;
   int err_total;
   int compares;
   int seed;
   logic [31:0] q [$];

   imdv_regs #(.TICK_CYCLES(TCK)) DUT (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_data(acc_data),
      .gyro_valid(gyro_valid), .gyro_x_in(gin[0]), .gyro_y_in(gin[1]), .gyro_z_in(gin[2]),
      .gyro_x_out(gout[0]), .gyro_y_out(gout[1]), .gyro_z_out(gout[2]),
      .sample_tick(sample_tick));
   imdv_host host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_word

   task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp_val

   function automatic logic [31:0] sat_add(input logic [31:0] a, input logic [31:0] b);
      logic signed [32:0] s;
      s = $signed({a[31], a}) + $signed({b[31], b});
      if (s[32] != s[31])
         return s[32] ? SAT_NEG : SAT_POS;
      return s[31:0];
   endfunction : sat_add

   function automatic logic [31:0] exp_vel(input logic [31:0] a, input logic [31:0] b);
      logic signed [32:0] s;
      s = $signed({a[31], a}) + $signed({b[31], b});
      return s[32:1];
   endfunction : exp_vel

   task automatic rd_vel(output logic [31:0] v);
      host.rd(OFS_ZV_LO, v[15:0]);
      host.rd(OFS_ZV_HI, v[31:16]);
   endtask : rd_vel

   // Counts falling edges until the cycle that carries a sample tick.
   task automatic wait_tick(output int n);
      n = 0;
      do
      begin
         @(negedge core_clk);
         n++;
      end
      while (sample_tick !== 1'b1 && n < 1000);
   endtask : wait_tick

   task automatic push_one(input logic [31:0] d);
      @(negedge core_clk);
      while (acc_ready !== 1'b1)
         @(negedge core_clk);
      acc_valid = 1'b1;
      acc_data = d;
      @(negedge core_clk);
      acc_valid = 1'b0;
      acc_data = ~d;
   endtask : push_one

   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #(20000 * 10);
      err_total++;
      $display("unexpected at %0t: watchdog %h expected %h", $time, 1'b1, 1'b0);
      tally_and_finish();
   end

   initial
   begin
      logic [15:0] w;
      logic [31:0] v;
      logic [31:0] got;
      logic [31:0] prev;
      logic [31:0] ofs [3];
      int n;
      seed = 32'hd34371c1;
      err_total = 0;
      compares = 0;
      rst = 1'b1;
      acc_valid = 1'b0;
      acc_data = 32'h0000_0000;
      gyro_valid = 1'b0;
      for (int k = 0; k < 3; k++)
         gin[k] = 32'h0000_0000;
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      // Reset values, unmapped address.
      for (int k = 0; k < 6; k++)
      begin
         host.rd(OFS_XB_LO + 8'(2 * k), w);
         cmp_word(w, BIAS_RST);
      end
      host.wr(8'h50, 16'(unsigned'($random(seed))));
      host.rd(8'h50, w);
      cmp_word(w, RD_NONE);
      $display("test reset done");
      // Offset words and corrected gyro rates, saturating corners first.
      for (int i = 0; i < 3; i++)
      begin
         for (int k = 0; k < 3; k++)
         begin
            ofs[k] = (i == 0) ? SAT_POS : (i == 1) ? SAT_NEG : $random(seed);
            host.wr(OFS_XB_LO + 8'(4 * k), ofs[k][15:0]);
            host.wr(OFS_XB_HI + 8'(4 * k), ofs[k][31:16]);
            host.rd(OFS_XB_HI + 8'(4 * k), w);
            cmp_word(w, ofs[k][31:16]);
            host.rd(OFS_XB_LO + 8'(4 * k) + 8'h01, w);
            cmp_word(w, ofs[k][15:0]);
            gin[k] = $random(seed);
         end
         @(negedge core_clk);
         gyro_valid = 1'b1;
         @(negedge core_clk);
         gyro_valid = 1'b0;
         wait_tick(n);
         @(negedge core_clk);
         for (int k = 0; k < 3; k++)
            cmp_val(gout[k], sat_add(gin[k], ofs[k]));
      end
      wait_tick(n);
      wait_tick(n);
      cmp_val(32'(n), 32'(TCK));
      $display("test gyro done");
      // Velocity words from single samples, format corners first.
      prev = 32'h0000_0000;
      for (int i = 0; i < 10; i++)
      begin
         v = (i < 6) ? CORNER[i] : $random(seed);
         push_one(v);
         repeat (TCK + 5) @(negedge core_clk);
         rd_vel(got);
         cmp_val(got, exp_vel(v, prev));
         prev = v;
      end
      rd_vel(v);
      host.wr(OFS_ZV_LO, ~v[15:0]);
      host.wr(OFS_ZV_HI, ~v[31:16]);
      rd_vel(got);
      cmp_val(got, v);
      $display("test velocity done");
      // Fill the sample buffer until it refuses, then let ticks drain it.
      q.delete();
      @(negedge core_clk);
      while (acc_ready === 1'b1)
      begin
         acc_valid = 1'b1;
         acc_data = $random(seed);
         q.push_back(acc_data);
         @(negedge core_clk);
      end
      acc_valid = 1'b0;
      acc_data = ~acc_data;
      cmp_val(32'(q.size() inside {FIFO_DEPTH, FIFO_DEPTH + 1}), 32'd1);
      repeat ((FIFO_DEPTH + 3) * TCK) @(negedge core_clk);
      cmp_val({31'd0, acc_ready}, 32'd1);
      rd_vel(got);
      cmp_val(got, exp_vel(q[q.size() - 1], q[q.size() - 2]));
      $display("test buffer done");
      tally_and_finish();
   end
endmodule : imdv_regs_bench
